// ==== src/charger_consts.svh ====
// constants of the charger register bank
// assumes inclusion by bare name
`ifndef CHARGER_CONSTS_SVH
`define CHARGER_CONSTS_SVH

// bus address 0x12, which is 0x09 in 7-bit form
`define SLAVE_ADDR7        7'h09

// register command codes
`define REG_MODE           8'h12
`define REG_STATUS         8'h13
`define REG_ICHG           8'h14
`define REG_VCHG           8'h15
`define REG_IIN            8'h3F

// reset values
`define MODE_RESET         16'h0001
`define STATUS_RESET       16'h0041
`define SETTING_RESET      16'h0000

// mode control fields
`define MODE_INHIBIT_BIT   0
`define MODE_LEARN_BIT     1

// status fields
`define STAT_UNREADY_BIT   0
`define STAT_VOR_BIT       4
`define STAT_BATT_BIT      6
`define STAT_ADPT_BIT      7

// decoded fields of the setting words
`define CURR_LSB           7
`define CURR_MSB           14
`define VOLT_LSB           1
`define VOLT_MSB           14

// voltage ranges in millivolts
`define PRE_MV             15'h2328
`define V3_MIN_MV          15'h2EE0
`define V3_MAX_MV          15'h3840
`define V4_MIN_MV          15'h3E80
`define V4_MAX_MV          15'h4B00
// 3-cell step 18.75 mV as mV*4/75
`define V3_STEP_MUL        17'h00004
`define V3_STEP_DIV        17'h0004B
// 4-cell step 25 mV
`define V4_STEP_MV         15'h0019
`define DAC_CODE_MAX       7'h7F

// timing
`define CLK_PERIOD_NS      5
`define LDO_DELAY_MS       5
`define ADAPTER_DELAY_MS   500
`define NS_PER_MS          1000000

`endif

// ==== src/charger_pkg.sv ====
// types of the charger register bank
// assumes nothing of its surroundings
package charger_pkg;

  // bus engine states
  typedef enum logic [3:0] {
    SMB_IDLE      = 4'h0,
    SMB_ADDR      = 4'h1,
    SMB_ADDR_ACK  = 4'h2,
    SMB_CMD       = 4'h3,
    SMB_CMD_ACK   = 4'h4,
    SMB_WDATA     = 4'h5,
    SMB_WDATA_ACK = 4'h6,
    SMB_RDATA     = 4'h7,
    SMB_RACK      = 4'h8,
    SMB_RNEXT     = 4'h9
  } smb_state_t;

  // decoded battery voltage range
  typedef enum logic [1:0] {
    VR_OFF   = 2'h0,
    VR_PRE   = 2'h1,
    VR_3CELL = 2'h2,
    VR_4CELL = 2'h3
  } vrange_t;

endpackage

// ==== src/vdec_if.sv ====
// carrier to the voltage decoder
// assumes charger_pkg compiled first
`timescale 1ns/10ps
interface vdec_if;
  import charger_pkg::*;
  logic [15:0] word;   // raw voltage setting word
  vrange_t     range;  // decoded range
  logic [6:0]  code;   // per-cell converter code
  logic        oor;    // requested voltage out of range

  modport dec  (input word, output range, code, oor);
  modport user (output word, input range, code, oor);
endinterface

// ==== src/voltage_code_decoder.sv ====
// maps the voltage word to a range and per-cell code
// assumes the user registers the outputs
`timescale 1ns/10ps
`include "charger_consts.svh"
module voltage_code_decoder (
  // setting word in, decoded code out
  vdec_if.dec vd
);
  import charger_pkg::*;

  logic [14:0] mv;  // millivolts from the used field
  logic [16:0] q3;  // 3-cell quotient
  logic [14:0] q4;  // 4-cell quotient

  // range and truncated code
  always_comb begin
    mv = {vd.word[`VOLT_MSB:`VOLT_LSB], 1'b0};
    q3 = ({2'b00, mv - `V3_MIN_MV} * `V3_STEP_MUL) / `V3_STEP_DIV;
    q4 = (mv - `V4_MIN_MV) / `V4_STEP_MV;
    vd.range = VR_OFF;
    vd.code  = 7'h00;
    vd.oor   = 1'b0;
    if (mv == 15'h0000) begin
      // reset value: disabled, not flagged
      vd.range = VR_OFF;
    end else if (mv == `PRE_MV) begin
      vd.range = VR_PRE;
    end else if (mv < `V3_MIN_MV || (mv > `V3_MAX_MV && mv < `V4_MIN_MV)) begin
      vd.oor = 1'b1;
    end else if (mv <= `V3_MAX_MV) begin
      vd.range = VR_3CELL;
      vd.code  = (q3 > 17'h0007F) ? `DAC_CODE_MAX : q3[6:0];
    end else begin
      vd.range = VR_4CELL;
      // above the top: clamp
      vd.code  = (mv >= `V4_MAX_MV || q4 > 15'h007F) ? `DAC_CODE_MAX : q4[6:0];
    end
  end

endmodule

// ==== src/charger_smbus_register_bank.sv ====
// charger host-control logic: bus slave, registers, voltage mapping,
// alarm and power sequencing
// assumes scl/sda sampled synchronous to clk; open-drain pads outside
//
// Function
// - answer bus slave address 0x12, word access
// - no packet error byte appended or expected
// - exactly five 16-bit host registers
// - decode 0x15,0x14,0x3F,0x12,0x13 register addresses
// - status change pulls alarm line low
// - alarm released only by status register read
// - no watchdog; settings persist, operation continues
// - use voltage bits 1..14, 7-bit code
// - ranges: 9 V, 3-cell, 4-cell
// - between steps truncate to lower code
// - above 19.2 V clamp to maximum
// - gap or low voltage disables, flags, alarms
// - voltage setting resets to 0 V
// - charge current from bits 7..14, zero disables
// - input current from bits 7..14, zero disables
// - reference LDO off without adapter, delayed 5 ms
// - 500 ms delay before switch and charger
// - adapter powers system when detected, else battery
// - learn mode connects battery instead of adapter
// - charge needs pin low and inhibit bit clear
// - status bits 6/7 show battery/adapter connection
// - status bit 0 high while not ready
`timescale 1ns/10ps
`include "charger_consts.svh"
module charger_smbus_register_bank #(
  parameter int unsigned LDO_DELAY_CYC     = `LDO_DELAY_MS * `NS_PER_MS / `CLK_PERIOD_NS,
  parameter int unsigned ADAPTER_DELAY_CYC = `ADAPTER_DELAY_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // bus pins; data is open drain
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  // alarm open-drain pin
  output logic                     alarm_out,
  output logic                     alarm_oe_n,
  // analog status inputs
  input  wire logic                adapter_detect,
  input  wire logic                gate_drive_regulator_up,
  input  wire logic                five_volt_reference_ldo_up,
  input  wire logic                charge_enable_pin_n,
  // power control outputs
  output logic                     five_volt_reference_ldo_en,
  output logic                     five_volt_reference_ldo_pulldown,
  output logic                     adapter_switch_transistor_on,
  output logic                     battery_switch_on,
  output logic                     charger_en,
  // converter settings
  output charger_pkg::vrange_t     voltage_range,
  output logic [6:0]               voltage_code,
  output logic [7:0]               charge_current_code,
  output logic [7:0]               input_current_code
);
  import charger_pkg::*;

  // reset synchroniser
  logic        rst_meta_reg;  // first stage, read only by second
  logic        rst_n;         // released reset for the design

  // bus engine state
  smb_state_t  st_reg, st_next;           // transaction phase
  logic [3:0]  cnt_reg, cnt_next;         // bits seen in the byte
  logic [7:0]  shift_reg, shift_next;     // incoming byte
  logic [7:0]  cmd_reg, cmd_next;         // latched command byte
  logic        cmd_ok_reg, cmd_ok_next;   // command accepted this frame
  logic [7:0]  lo_reg, lo_next;           // written low byte
  logic        hi_reg, hi_next;           // second byte phase
  logic        sda_low_reg, sda_low_next; // pull data line low
  logic [15:0] tx_reg, tx_next;           // outgoing word, MSB shifted out
  logic        scl_q_reg, sda_q_reg;      // previous pin samples
  logic        wr_pulse;                  // write word complete
  logic        stat_rd_pulse;             // status read complete

  // host registers
  logic [15:0] mode_reg, mode_next;
  logic [15:0] vchg_reg, vchg_next;
  logic [15:0] ichg_reg, ichg_next;
  logic [15:0] iin_reg, iin_next;
  logic [15:0] status_reg, status_next;
  logic        alarm_reg, alarm_next;

  // sequencing
  logic [31:0] adp_cnt_reg, adp_cnt_next;  // time since adapter detect
  logic [31:0] ldo_cnt_reg, ldo_cnt_next;  // time with adapter and gate regulator both up
  logic        adp_done, ldo_done;
  logic        ready, adp_sw, chg_ok;

  // registered converter settings
  vrange_t     vrange_reg;
  logic [6:0]  vcode_reg;
  logic [7:0]  icode_reg, incode_reg;
  logic        ldo_en_reg, ldo_pd_reg, adp_sw_reg, chg_en_reg;

  // bus pin conditions
  logic        scl_rise, scl_fall, start_c, stop_c, rx_done;
  logic [15:0] rd_word;

  // voltage decoder
  vdec_if vdec ();
  voltage_code_decoder u_vdec (
    .vd (vdec.dec)
  );
  assign vdec.word = vchg_reg;

  // true for the five command codes
  function automatic logic is_mapped(input logic [7:0] c);
    is_mapped = (c == `REG_MODE) || (c == `REG_STATUS) || (c == `REG_ICHG) ||
                (c == `REG_VCHG) || (c == `REG_IIN);
  endfunction

  // read data for a command
  function automatic logic [15:0] reg_value(input logic [7:0] c);
    case (c)
      `REG_MODE:   reg_value = mode_reg;
      `REG_STATUS: reg_value = status_reg;
      `REG_ICHG:   reg_value = ichg_reg;
      `REG_VCHG:   reg_value = vchg_reg;
      `REG_IIN:    reg_value = iin_reg;
      default:     reg_value = 16'h0000;
    endcase
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // pin edge and frame conditions
  always_comb begin
    scl_rise = scl_in & ~scl_q_reg;
    scl_fall = ~scl_in & scl_q_reg;
    start_c  = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    stop_c   = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
    rx_done  = scl_fall && (cnt_reg == 4'h8);
    rd_word  = reg_value(cmd_reg);
  end

  // bus engine next state
  always_comb begin
    st_next       = st_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    cmd_next      = cmd_reg;
    cmd_ok_next   = cmd_ok_reg;
    lo_next       = lo_reg;
    hi_next       = hi_reg;
    sda_low_next  = sda_low_reg;
    tx_next       = tx_reg;
    wr_pulse      = 1'b0;
    stat_rd_pulse = 1'b0;
    if (start_c) begin
      // start or repeated start
      st_next      = SMB_ADDR;
      cnt_next     = 4'h0;
      sda_low_next = 1'b0;
      hi_next      = 1'b0;
    end else if (stop_c) begin
      // stop ends the frame and forgets the command
      st_next      = SMB_IDLE;
      sda_low_next = 1'b0;
      cmd_ok_next  = 1'b0;
    end else begin
      case (st_reg)
        SMB_ADDR, SMB_CMD, SMB_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_in};
            cnt_next   = cnt_reg + 4'h1;
          end else if (rx_done) begin
            cnt_next = 4'h0;
            if (st_reg == SMB_ADDR) begin
              // read only allowed after an accepted command byte
              if (shift_reg[7:1] == `SLAVE_ADDR7 && (!shift_reg[0] || cmd_ok_reg)) begin
                sda_low_next = 1'b1;
                st_next      = SMB_ADDR_ACK;
                tx_next      = shift_reg[0] ? {rd_word[7:0], rd_word[15:8]} : tx_reg;
              end else begin
                st_next = SMB_IDLE;
              end
            end else if (st_reg == SMB_CMD) begin
              // unmapped commands get no ack
              if (is_mapped(shift_reg)) begin
                cmd_next     = shift_reg;
                cmd_ok_next  = 1'b1;
                sda_low_next = 1'b1;
                st_next      = SMB_CMD_ACK;
              end else begin
                st_next = SMB_IDLE;
              end
            end else begin
              sda_low_next = 1'b1;
              st_next      = SMB_WDATA_ACK;
              if (!hi_reg) begin
                lo_next = shift_reg;
              end else begin
                wr_pulse = 1'b1;
              end
            end
          end
        end
        SMB_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_next = 4'h0;
            if (shift_reg[0]) begin
              // read: drive the first data bit
              st_next      = SMB_RDATA;
              sda_low_next = ~tx_reg[15];
              tx_next      = {tx_reg[14:0], 1'b0};
            end else begin
              st_next      = SMB_CMD;
              sda_low_next = 1'b0;
              cmd_ok_next  = 1'b0;
            end
          end
        end
        SMB_CMD_ACK: begin
          if (scl_fall) begin
            sda_low_next = 1'b0;
            hi_next      = 1'b0;
            st_next      = SMB_WDATA;
          end
        end
        SMB_WDATA_ACK: begin
          if (scl_fall) begin
            // no error-check byte follows the high byte
            sda_low_next = 1'b0;
            hi_next      = 1'b1;
            st_next      = hi_reg ? SMB_IDLE : SMB_WDATA;
          end
        end
        SMB_RDATA: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              sda_low_next = 1'b0;
              st_next      = SMB_RACK;
            end else begin
              sda_low_next = ~tx_reg[15];
              tx_next      = {tx_reg[14:0], 1'b0};
            end
          end
        end
        SMB_RACK: begin
          if (scl_rise) begin
            if (!sda_in && !hi_reg) begin
              st_next = SMB_RNEXT;
            end else begin
              // word done, no error-check byte sent
              st_next       = SMB_IDLE;
              stat_rd_pulse = (cmd_reg == `REG_STATUS);
            end
          end
        end
        SMB_RNEXT: begin
          if (scl_fall) begin
            hi_next      = 1'b1;
            cnt_next     = 4'h0;
            st_next      = SMB_RDATA;
            sda_low_next = ~tx_reg[15];
            tx_next      = {tx_reg[14:0], 1'b0};
          end
        end
        default: begin
          st_next = SMB_IDLE;
        end
      endcase
    end
  end

  // bus engine registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg      <= SMB_IDLE;
      cnt_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      cmd_reg     <= 8'h00;
      cmd_ok_reg  <= 1'b0;
      lo_reg      <= 8'h00;
      hi_reg      <= 1'b0;
      sda_low_reg <= 1'b0;
      tx_reg      <= 16'h0000;
      scl_q_reg   <= 1'b1;
      sda_q_reg   <= 1'b1;
    end else begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      cmd_reg     <= cmd_next;
      cmd_ok_reg  <= cmd_ok_next;
      lo_reg      <= lo_next;
      hi_reg      <= hi_next;
      sda_low_reg <= sda_low_next;
      tx_reg      <= tx_next;
      scl_q_reg   <= scl_in;
      sda_q_reg   <= sda_in;
    end
  end

  // host register writes; status is read only
  always_comb begin
    mode_next = mode_reg;
    vchg_next = vchg_reg;
    ichg_next = ichg_reg;
    iin_next  = iin_reg;
    if (wr_pulse) begin
      case (cmd_reg)
        `REG_MODE: mode_next = {shift_reg, lo_reg};
        `REG_VCHG: vchg_next = {shift_reg, lo_reg};
        `REG_ICHG: ichg_next = {shift_reg, lo_reg};
        `REG_IIN:  iin_next  = {shift_reg, lo_reg};
        default:   mode_next = mode_reg;
      endcase
    end
  end

  // settings hold until rewritten, no watchdog
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `MODE_RESET;
      vchg_reg <= `SETTING_RESET;
      ichg_reg <= `SETTING_RESET;
      iin_reg  <= `SETTING_RESET;
    end else begin
      mode_reg <= mode_next;
      vchg_reg <= vchg_next;
      ichg_reg <= ichg_next;
      iin_reg  <= iin_next;
    end
  end

  // sequencing and status next values
  always_comb begin
    adp_done     = (adp_cnt_reg == 32'(ADAPTER_DELAY_CYC));
    ldo_done     = (ldo_cnt_reg == 32'(LDO_DELAY_CYC));
    adp_cnt_next = !adapter_detect ? 32'h0000_0000 :
                   adp_done ? adp_cnt_reg : adp_cnt_reg + 32'h0000_0001;
    ldo_cnt_next = !(adapter_detect && gate_drive_regulator_up) ? 32'h0000_0000 :
                   ldo_done ? ldo_cnt_reg : ldo_cnt_reg + 32'h0000_0001;
    ready  = adapter_detect && adp_done && gate_drive_regulator_up &&
             five_volt_reference_ldo_up;
    // battery stays on the system through the delay and in learn mode
    adp_sw = adapter_detect && adp_done && !mode_reg[`MODE_LEARN_BIT];
    chg_ok = ready && !charge_enable_pin_n && !mode_reg[`MODE_INHIBIT_BIT] &&
             (vdec.range != VR_OFF) &&
             (ichg_reg[`CURR_MSB:`CURR_LSB] != 8'h00) &&
             (iin_reg[`CURR_MSB:`CURR_LSB] != 8'h00);
    status_next = 16'h0000;
    status_next[`STAT_UNREADY_BIT] = ~ready;
    status_next[`STAT_VOR_BIT]     = vdec.oor;
    status_next[`STAT_BATT_BIT]    = ~adp_sw;
    status_next[`STAT_ADPT_BIT]    = adp_sw;
    // a change wins over a same-cycle status read
    if (status_next != status_reg) begin
      alarm_next = 1'b1;
    end else if (stat_rd_pulse) begin
      alarm_next = 1'b0;
    end else begin
      alarm_next = alarm_reg;
    end
  end

  // sequencing, status and converter registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adp_cnt_reg <= 32'h0000_0000;
      ldo_cnt_reg <= 32'h0000_0000;
      status_reg  <= `STATUS_RESET;
      alarm_reg   <= 1'b0;
      vrange_reg  <= VR_OFF;
      vcode_reg   <= 7'h00;
      icode_reg   <= 8'h00;
      incode_reg  <= 8'h00;
      ldo_en_reg  <= 1'b0;
      ldo_pd_reg  <= 1'b1;
      adp_sw_reg  <= 1'b0;
      chg_en_reg  <= 1'b0;
    end else begin
      adp_cnt_reg <= adp_cnt_next;
      ldo_cnt_reg <= ldo_cnt_next;
      status_reg  <= status_next;
      alarm_reg   <= alarm_next;
      vrange_reg  <= vdec.range;
      vcode_reg   <= vdec.code;
      icode_reg   <= ichg_reg[`CURR_MSB:`CURR_LSB];
      incode_reg  <= iin_reg[`CURR_MSB:`CURR_LSB];
      ldo_en_reg  <= adapter_detect && ldo_done;
      ldo_pd_reg  <= !adapter_detect;
      adp_sw_reg  <= adp_sw;
      chg_en_reg  <= chg_ok;
    end
  end

  // pin and output drive
  always_comb begin
    sda_out                          = 1'b0;
    sda_oe_n                         = ~sda_low_reg;
    alarm_out                        = 1'b0;
    alarm_oe_n                       = ~alarm_reg;
    five_volt_reference_ldo_en       = ldo_en_reg;
    five_volt_reference_ldo_pulldown = ldo_pd_reg;
    adapter_switch_transistor_on     = adp_sw_reg;
    battery_switch_on                = ~adp_sw_reg;
    charger_en                       = chg_en_reg;
    voltage_range                    = vrange_reg;
    voltage_code                     = vcode_reg;
    charge_current_code              = icode_reg;
    input_current_code               = incode_reg;
  end

endmodule

// ==== sim/charger_smbus_register_bank_monitor.sv ====
// port checker for the charger register bank
// assumes binding into the top module
`timescale 1ns/10ps
module charger_smbus_register_bank_monitor #(
  parameter int unsigned LDO_DELAY_CYC     = 8,
  parameter int unsigned ADAPTER_DELAY_CYC = 40
) (
  // clock, reset, bus and alarm
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic alarm_oe_n,
  // analog status
  input wire logic adapter_detect,
  input wire logic gate_drive_regulator_up,
  input wire logic charge_enable_pin_n,
  // power control
  input wire logic five_volt_reference_ldo_en,
  input wire logic five_volt_reference_ldo_pulldown,
  input wire logic adapter_switch_transistor_on,
  input wire logic battery_switch_on,
  input wire logic charger_en
);
  int unsigned ldo_cnt_reg;  // run of adapter with gate drive up
  int unsigned adp_cnt_reg;  // run of adapter present
  // run-length counters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ldo_cnt_reg <= 0;
      adp_cnt_reg <= 0;
    end else begin
      ldo_cnt_reg <= (adapter_detect && gate_drive_regulator_up) ? ldo_cnt_reg + 1 : 0;
      adp_cnt_reg <= adapter_detect ? adp_cnt_reg + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // inputs settled
  sequence s_no_adapter;
    !adapter_detect [*4];
  endsequence
  sequence s_pin_high;
    charge_enable_pin_n [*4];
  endsequence
  a_selector_one_path: assert property (
    battery_switch_on != adapter_switch_transistor_on)
    else $error("selector drives both or neither path");
  a_ldo_held_off: assert property (
    s_no_adapter |-> !five_volt_reference_ldo_en && five_volt_reference_ldo_pulldown)
    else $error("reference on without adapter");
  a_ldo_delay_min: assert property (
    $rose(five_volt_reference_ldo_en) |-> ldo_cnt_reg >= LDO_DELAY_CYC)
    else $error("reference enabled early");
  a_switch_delay_min: assert property (
    $rose(adapter_switch_transistor_on) || $rose(charger_en) |-> adp_cnt_reg >= ADAPTER_DELAY_CYC)
    else $error("switch or charger on before delay");
  a_pin_blocks_charge: assert property (s_pin_high |-> !charger_en)
    else $error("charging with enable pin high");
  a_alarm_release: assert property ($rose(alarm_oe_n) |-> scl_in)
    else $error("alarm released outside a read");
  a_alarm_on_switch: assert property (
    $changed(adapter_switch_transistor_on) |-> ##[0:4] !alarm_oe_n)
    else $error("no alarm after selector change");
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data moved with clock high");
endmodule

// ==== sim/smbus_host_model.sv ====
// bus master standing in for the embedded controller host
// assumes a pull-up resolves the data line in the bench
`timescale 1ns/10ps
module smbus_host_model (
  // clock and resolved data line
  input  wire logic clk,
  input  wire logic sda,
  // host-driven pins
  output logic      scl = 1'b1,
  output logic      sda_h = 1'b1
);
  // one bus phase of five clocks
  task automatic phase;
    repeat (5) @(posedge clk);
  endtask
  // start or repeated start
  task automatic start;
    sda_h <= 1'b1;
    phase;
    scl <= 1'b1;
    phase;
    sda_h <= 1'b0;
    phase;
    scl <= 1'b0;
  endtask
  // stop
  task automatic stop;
    sda_h <= 1'b0;
    phase;
    scl <= 1'b1;
    phase;
    sda_h <= 1'b1;
    phase;
  endtask
  // nine bits; d[0] is the host's ninth bit
  task automatic byte_x(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_h <= d[i];
      phase;
      scl <= 1'b1;
      phase;
      q[i] = sda;
      scl <= 1'b0;
    end
  endtask
  // write word
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic nak);
    logic [8:0]  q;
    logic [31:0] s;
    s = {8'h12, cmd, d[7:0], d[15:8]};  // low byte first, no check byte
    nak = 1'b0;
    start;
    for (int k = 3; k >= 0; k--) begin
      byte_x({s[8*k +: 8], 1'b1}, q);
      nak |= q[0];
    end
    stop;
  endtask
  // read word with repeated start
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic nak);
    logic [8:0] q;
    start;
    byte_x(9'h025, q);
    nak = q[0];
    byte_x({cmd, 1'b1}, q);
    nak |= q[0];
    start;
    byte_x(9'h027, q);
    nak |= q[0];
    byte_x(9'h1FE, q);
    d[7:0] = q[8:1];
    byte_x(9'h1FF, q);  // no check byte follows
    d[15:8] = q[8:1];
    stop;
  endtask
endmodule

// ==== sim/charger_smbus_register_bank_tb_top.sv ====
// self-checking bench for the charger register bank
// assumes design, host and checker compiled first
`timescale 1ns/10ps
module charger_smbus_register_bank_tb_top;
  import charger_pkg::*;
  localparam int unsigned LDO_CYC = 8;   // shortened reference delay
  localparam int unsigned ADP_CYC = 40;  // shortened adapter delay
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        adapter_detect = 1'b0;
  logic        gate_drive_regulator_up = 1'b0;
  logic        five_volt_reference_ldo_up = 1'b0;
  logic        charge_enable_pin_n = 1'b0;
  logic        scl_in, sda_h, sda_out, sda_oe_n, alarm_out, alarm_oe_n, nak, voltage_out_of_range_flag;
  logic        five_volt_reference_ldo_en, five_volt_reference_ldo_pulldown, charger_en;
  logic        adapter_switch_transistor_on, battery_switch_on;
  vrange_t     voltage_range;
  logic [6:0]  voltage_code;
  logic [7:0]  charge_current_code, input_current_code;
  logic [6:0]  m;
  logic [15:0] rd;
  int          n_errors = 0;
  int          n_tests = 0;
  wire         sda_in = sda_h & (sda_oe_n | sda_out);  // open drain with pull-up
  wire         alarm = alarm_oe_n | alarm_out;
  wire [15:0]  pw = {11'h000, five_volt_reference_ldo_en, five_volt_reference_ldo_pulldown,
                     adapter_switch_transistor_on, battery_switch_on, charger_en};
  // voltage words and expected {flag, range, code}
  logic [15:0] vw [12] = '{16'h2328, 16'h2EE0, 16'h2F04, 16'h3840, 16'h3A98, 16'h1388,
                           16'h0000, 16'h3E80, 16'h3E9E, 16'h4B00, 16'h4E20, 16'hBE81};
  logic [9:0]  ve [12] = '{10'h080, 10'h100, 10'h101, 10'h17F, 10'h200, 10'h200,
                           10'h000, 10'h180, 10'h181, 10'h1FF, 10'h1FF, 10'h180};
  logic [7:0]  rc [5] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h3F};
  logic [15:0] rv [5] = '{16'h0001, 16'h0041, 16'h0000, 16'h0000, 16'h0000};
  always #2.5 clk = ~clk;
  charger_smbus_register_bank #(.LDO_DELAY_CYC(LDO_CYC), .ADAPTER_DELAY_CYC(ADP_CYC)) uut (.*);
  smbus_host_model host (.clk(clk), .sda(sda_in), .scl(scl_in), .sda_h(sda_h));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
    host.read_word(cmd, rd, nak);
    chk("read ack", 16'h0000, {15'h0000, nak});
    chk("read data", exp, rd);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    host.write_word(cmd, d, nak);
    chk("write ack", 16'h0000, {15'h0000, nak});
  endtask
  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 5; i++) rd_chk(rc[i], rv[i]);
    wr(8'h13, 16'hFFFF);
    rd_chk(8'h13, 16'h0041);
    host.read_word(8'h16, rd, nak);
    chk("unmapped nack", 16'h0001, {15'h0000, nak});
    wr(8'h14, 16'h807F);
    chk("charge code", 16'h0000, {8'h00, charge_current_code});
    wr(8'h14, 16'hFFFF);
    chk("charge code", 16'h00FF, {8'h00, charge_current_code});
    rd_chk(8'h14, 16'hFFFF);
    wr(8'h3F, 16'h4000);
    chk("input code", 16'h0080, {8'h00, input_current_code});
    // voltage table; code masked where no range
    voltage_out_of_range_flag = 1'b0;
    for (int i = 0; i < 12; i++) begin
      wr(8'h15, vw[i]);
      chk("alarm", {15'h0000, ve[i][9] == voltage_out_of_range_flag}, {15'h0000, alarm});
      m = {7{|ve[i][8:7]}};
      chk("vcode", {7'h00, ve[i][8:0]}, {7'h00, voltage_range, voltage_code & m});
      voltage_out_of_range_flag = ve[i][9];
      rd_chk(8'h13, {10'h001, 1'b0, voltage_out_of_range_flag, 4'h1});
      chk("alarm clear", 16'h0001, {15'h0000, alarm});
    end
    // power path sequencing
    wr(8'h14, 16'h0080);
    wr(8'h12, 16'h0000);
    chk("power", 16'h000A, pw);
    {adapter_detect, gate_drive_regulator_up, five_volt_reference_ldo_up} <= 3'h7;
    repeat (LDO_CYC + 4) @(posedge clk);
    chk("power", 16'h0012, pw);
    repeat (ADP_CYC) @(posedge clk);
    chk("power", 16'h0015, pw);
    chk("alarm", 16'h0000, {15'h0000, alarm});
    rd_chk(8'h13, 16'h0080);
    wr(8'h12, 16'h0001);
    chk("power", 16'h0014, pw);
    wr(8'h12, 16'h0000);
    charge_enable_pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("power", 16'h0014, pw);
    charge_enable_pin_n <= 1'b0;
    wr(8'h12, 16'h0003);
    chk("power", 16'h0012, pw);
    rd_chk(8'h13, 16'h0040);
    wr(8'h12, 16'h0000);
    wr(8'h14, 16'h0000);
    chk("power", 16'h0014, pw);
    {adapter_detect, gate_drive_regulator_up, five_volt_reference_ldo_up} <= 3'h0;
    repeat (6) @(posedge clk);
    chk("power", 16'h000A, pw);
    rd_chk(8'h13, 16'h0041);
    rd_chk(8'h15, 16'hBE81);
    final_report;
  end
endmodule
bind charger_smbus_register_bank charger_smbus_register_bank_monitor #(
  .LDO_DELAY_CYC(LDO_DELAY_CYC), .ADAPTER_DELAY_CYC(ADAPTER_DELAY_CYC)) mon (.*);
